// *** bench/line_station.sv ***
// Remote station: makes the transmit clock and collects characters from the line
`timescale 1ns/100ps
module line_station (
	input wire logic run,
	input wire logic txd,
	input wire logic [3:0] nbits,
	output logic tx_clk,
	output logic [7:0] rx_char,
	output int n_rx
);
	logic [7:0] sh;
	// Clock parks high between bursts
	initial begin
		tx_clk = 1'b1;
		forever begin
			#200;
			if (run || !tx_clk) begin
				tx_clk = ~tx_clk;
			end
		end
	end
	// Sampled on the fall, just before the next bit is launched
	initial begin
		rx_char = 8'h00;
		n_rx = 0;
		forever begin
			@(negedge tx_clk);
			if (txd === 1'b0) begin
				sh = 8'h00;
				for (int i = 0; i < nbits; i++) begin
					@(negedge tx_clk);
					sh[i] = txd;
				end
				@(negedge tx_clk);
				rx_char = sh;
				n_rx++;
			end
		end
	end
endmodule : line_station

// *** bench/serial_tx_cfg_checker.sv ***
// Port assertions for the transmit configuration block
`timescale 1ns/100ps
`include "tx_cfg_params.svh"
module serial_tx_cfg_checker (
	input logic sys_clk,
	input logic rst_b,
	input tx_cfg_pkg::reg_req_s bus,
	input tx_cfg_pkg::byte_t rdata,
	input logic txd,
	input logic rts_b,
	input logic tx_buf_irq,
	input logic tx_dma_req,
	input logic rx_special_irq,
	input logic rx_special_load,
	input logic crc16_sel,
	input tx_cfg_pkg::byte_t sync_address
);
	import tx_cfg_pkg::*;
	logic en_reg, en_next, brk_reg, brk_next, txw, cmdw;
	logic [7:0] hold_reg, hold_next;
	assign txw = bus.wr && bus.addr == `A_TXCTL;
	assign cmdw = bus.wr && bus.addr == `A_CMD && (bus.wdata[`CM_CRST] || bus.wdata[`CM_HRST]);
	// Counts cycles since enable or break last changed
	always_comb begin
		en_next = txw ? bus.wdata[`TC_EN] : en_reg && !cmdw;
		brk_next = txw ? bus.wdata[`TC_BRK] : brk_reg && !cmdw;
		hold_next = (hold_reg == 8'hFF) ? hold_reg : hold_reg + 8'h01;
		if (en_next != en_reg || brk_next != brk_reg) begin
			hold_next = 8'h00;
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_reg <= 1'b0;
			brk_reg <= 1'b0;
			hold_reg <= 8'h00;
		end else begin
			en_reg <= en_next;
			brk_reg <= brk_next;
			hold_reg <= hold_next;
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 8'h00)
		else $error("rdata not idle");
	rd_unmapped_a: assert property (bus.rd && bus.addr == 4'hF |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	dma_gate_a: assert property (tx_dma_req |-> tx_buf_irq)
		else $error("dma request without empty buffer");
	special_gate_a: assert property (rx_special_irq |-> rx_special_load)
		else $error("special irq without load");
	sync_load_a: assert property (bus.wr && bus.addr == `A_SYNCA |=> sync_address == $past(bus.wdata))
		else $error("sync address not loaded");
	poly_load_a: assert property (txw |=> crc16_sel == $past(bus.wdata[`TC_POLY]))
		else $error("polynomial select wrong");
	rts_on_a: assert property (txw && bus.wdata[`TC_RTS] |=> !rts_b)
		else $error("send request not low");
	break_zero_a: assert property (hold_reg >= 8'h3C && brk_reg |-> !txd)
		else $error("line not zero in break");
	idle_ones_a: assert property (hold_reg == 8'hFF && !en_reg && !brk_reg |-> txd)
		else $error("line not idle high");
endmodule : serial_tx_cfg_checker

// *** bench/testbench.sv ***
// Self-checking bench for the transmit configuration block
`timescale 1ns/100ps
`include "tx_cfg_params.svh"
module testbench;
	import tx_cfg_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	reg_req_s bus = '0;
	byte_t rdata, sync_address, sync_flag, rx_char, v;
	logic tx_clk, txd, rts_b, req_b, tx_buf_irq, tx_dma_req, rx_avail_irq, rx_special_irq, crc16_sel, crc_pre;
	logic rx_all_int_en = 1'b0;
	logic rx_special_load = 1'b0;
	logic [3:0] rx_fifo_count = 4'h0;
	logic [3:0] nbits = 4'h8;
	logic run = 1'b0;
	int n_rx, seen, i, n_mismatch = 0, n_checks = 0, cycles = 0;
	localparam logic [7:0] L_CTL [6] = '{8'h68, 8'h48, 8'h28, 8'h08, 8'h08, 8'h08};
	localparam logic [7:0] L_DAT [6] = '{8'hA5, 8'hE5, 8'hD5, 8'hF1, 8'h8A, 8'h15};
	localparam logic [3:0] L_NB [6] = '{4'h8, 4'h6, 4'h7, 4'h1, 4'h4, 4'h5};
	localparam logic [7:0] L_EXP [6] = '{8'hA5, 8'h25, 8'h55, 8'h01, 8'h0A, 8'h15};
	serial_tx_cfg #(.TX_DEPTH(4)) u_serial_tx_cfg (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus), .rdata(rdata),
		.tx_clk(tx_clk), .rxd(1'b1), .rx_char_sync(1'b0), .rx_all_int_en(rx_all_int_en),
		.rx_fifo_count(rx_fifo_count), .rx_special_load(rx_special_load), .txd(txd), .rts_b(rts_b),
		.req_b(req_b), .tx_buf_irq(tx_buf_irq), .tx_dma_req(tx_dma_req), .rx_avail_irq(rx_avail_irq),
		.rx_special_irq(rx_special_irq), .crc16_sel(crc16_sel), .crc_preset_ones(crc_pre),
		.sync_address(sync_address), .sync_flag(sync_flag));
	line_station u_line_station (.run(run), .txd(txd), .nbits(nbits), .tx_clk(tx_clk), .rx_char(rx_char),
		.n_rx(n_rx));
	always #25 sys_clk = ~sys_clk;
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input byte_t d);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus <= '0;
		// Registers settle after the taking edge
		@(negedge sys_clk);
	endtask : wr
	task automatic rdc(input logic [3:0] a, input byte_t exp, input string name);
		@(posedge sys_clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus <= '0;
		@(negedge sys_clk);
		chk(name, exp, rdata);
	endtask : rdc
	// Bounded wait for the station to finish a character
	task automatic rx_chk(input byte_t exp);
		for (int k = 0; k < 600 && n_rx == seen; k++) @(posedge sys_clk);
		chk("line char", exp, rx_char);
	endtask : rx_chk
	task automatic send(input byte_t d, input logic [3:0] nb, input byte_t exp);
		repeat (20) @(posedge sys_clk);
		seen = n_rx;
		nbits = nb;
		wr(`A_DATA, d);
		rx_chk(exp);
	endtask : send
	task automatic stop_test();
		$display("TB: checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			$display("TB: timeout");
			stop_test();
		end
	end
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		rdc(`A_X0, 8'h20, "status");
		chk("pins", 8'h0E, {4'h0, txd, rts_b, tx_buf_irq, tx_dma_req});
		wr(`A_SYNCA, 8'h96);
		chk("sync addr", 8'h96, sync_address);
		wr(`A_EXT, 8'h01);
		wr(`A_SYNCF, 8'h40);
		chk("sync flag kept", 8'h00, sync_flag);
		rdc(`A_X2, 8'h40, "enh");
		rdc(`A_X1, `MODE_RST, "mode");
		wr(`A_EXT, 8'h00);
		wr(`A_SYNCF, 8'h7E);
		chk("sync flag", 8'h7E, sync_flag);
		wr(`A_LINK, 8'h80);
		wr(`A_TXCTL, 8'h6F);
		chk("crc sel", 8'h06, {5'h0, crc_pre, crc16_sel, rts_b});
		wr(`A_CMD, 8'h01);
		rdc(`A_X0, 8'h65, "txctl after reset");
		rdc(`A_X2, 8'h40, "enh after reset");
		rdc(4'hF, 8'h00, "unmapped");
		$display("TB: registers done");
		wr(`A_EXT, 8'h01);
		wr(`A_SYNCF, 8'h60);
		wr(`A_MISC, 8'h01);
		wr(`A_TXCTL, 8'h60);
		run <= 1'b1;
		chk("dma empty", 8'h01, {7'h0, tx_dma_req});
		seen = n_rx;
		wr(`A_DATA, L_DAT[0]);
		@(negedge sys_clk);
		chk("irq one queued", 8'h00, {6'h0, tx_buf_irq, tx_dma_req});
		repeat (200) @(posedge sys_clk);
		chk("no char disabled", seen[7:0], n_rx[7:0]);
		wr(`A_TXCTL, L_CTL[0]);
		rx_chk(L_EXP[0]);
		for (i = 1; i < 6; i++) begin
			wr(`A_TXCTL, L_CTL[i]);
			send(L_DAT[i], L_NB[i], L_EXP[i]);
		end
		$display("TB: lengths done");
		wr(`A_TXCTL, 8'h10);
		repeat (60) @(posedge sys_clk);
		chk("txd break", 8'h00, {7'h0, txd});
		wr(`A_TXCTL, 8'h00);
		repeat (300) @(posedge sys_clk);
		chk("txd idle", 8'h01, {7'h0, txd});
		$display("TB: break done");
		nbits = 4'h8;
		wr(`A_MODE, 8'h05);
		wr(`A_TXCTL, 8'h6A);
		seen = n_rx;
		wr(`A_DATA, 8'h3C);
		repeat (20) @(posedge sys_clk);
		wr(`A_TXCTL, 8'h68);
		chk("rts held", 8'h00, {7'h0, rts_b});
		rx_chk(8'h3C);
		chk("rts stop bit", 8'h00, {7'h0, rts_b});
		repeat (40) @(posedge sys_clk);
		chk("rts released", 8'h01, {7'h0, rts_b});
		wr(`A_MODE, 8'h00);
		wr(`A_TXCTL, 8'h02);
		wr(`A_TXCTL, 8'h00);
		chk("rts sync", 8'h01, {7'h0, rts_b});
		run <= 1'b0;
		$display("TB: send request done");
		wr(`A_SYNCF, 8'h48);
		rx_all_int_en <= 1'b1;
		rx_fifo_count <= 4'h1;
		repeat (2) @(posedge sys_clk);
		chk("avail low", 8'h00, {7'h0, rx_avail_irq});
		rx_fifo_count <= `RX_HALF;
		rx_special_load <= 1'b1;
		@(negedge sys_clk);
		chk("avail half", 8'h03, {6'h0, rx_avail_irq, rx_special_irq});
		wr(`A_SYNCF, 8'h40);
		rx_special_load <= 1'b0;
		rx_fifo_count <= 4'h1;
		@(negedge sys_clk);
		chk("avail each", 8'h01, {7'h0, rx_avail_irq});
		$display("TB: receive level done");
		stop_test();
	end
endmodule : testbench
bind serial_tx_cfg serial_tx_cfg_checker u_serial_tx_cfg_checker (.sys_clk(sys_clk), .rst_b(rst_b), .bus(bus),
	.rdata(rdata), .txd(txd), .rts_b(rts_b), .tx_buf_irq(tx_buf_irq), .tx_dma_req(tx_dma_req),
	.rx_special_irq(rx_special_irq), .rx_special_load(rx_special_load), .crc16_sel(crc16_sel),
	.sync_address(sync_address));

// *** core/serial_tx_cfg.sv ***
// Serial transmitter with its configuration and enhancement registers
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "tx_cfg_params.svh"
module serial_tx_cfg #(
	parameter int TX_DEPTH = 4
) (
	input logic sys_clk,
	input logic rst_b,
	input tx_cfg_pkg::reg_req_s bus,
	output tx_cfg_pkg::byte_t rdata,
	input logic tx_clk,
	input logic rxd,
	input logic rx_char_sync,
	input logic rx_all_int_en,
	input logic [3:0] rx_fifo_count,
	input logic rx_special_load,
	output logic txd,
	output logic rts_b,
	output logic req_b,
	output logic tx_buf_irq,
	output logic tx_dma_req,
	output logic rx_avail_irq,
	output logic rx_special_irq,
	output logic crc16_sel,
	output logic crc_preset_ones,
	output tx_cfg_pkg::byte_t sync_address,
	output tx_cfg_pkg::byte_t sync_flag
);
	import tx_cfg_pkg::*;

	localparam int PW = $clog2(TX_DEPTH);

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b, input logic [15:0] p);
		crc_step = (c >> 1) ^ ((c[0] ^ b) ? p : 16'h0000);
	endfunction : crc_step

	byte_t txctl_reg, txctl_next;
	byte_t synca_reg, synca_next;
	byte_t syncf_reg, syncf_next;
	byte_t enh_reg, enh_next;
	byte_t link_reg, link_next;
	byte_t misc_reg, misc_next;
	byte_t ext_reg, ext_next;
	byte_t mode_reg, mode_next;
	byte_t rdata_reg, rdata_next;
	byte_t status;
	logic [1:0] tck_sync_reg;
	logic [1:0] rxd_sync_reg;
	logic tck_d_reg;
	logic tx_fall;
	logic tx_rise;
	logic cmd_wr;
	logic chan_rst;
	logic eom_clr_cmd;
	logic txen;
	logic async_m;
	logic sdlc;
	logic x21;
	logic [15:0] poly;
	logic [15:0] preset;

	byte_t fifo_mem [TX_DEPTH];
	logic [PW-1:0] wp_reg, wp_next;
	logic [PW-1:0] rp_reg, rp_next;
	logic [PW:0] fcnt_reg, fcnt_next;
	logic fifo_empty;
	logic fifo_full;
	logic push;
	logic pop;

	tx_state_e st_reg, st_next;
	logic [15:0] sh_reg, sh_next, ld_sh;
	logic [4:0] cnt_reg, cnt_next, ld_cnt;
	logic [15:0] crc_reg, crc_next;
	logic crc_on_reg, crc_on_next;
	logic eom_reg, eom_next;
	logic txbit_reg, txbit_next;
	logic brk_reg, brk_next;
	logic last_reg, last_next;
	logic txd_reg, txd_next;
	logic avail;
	logic take;
	logic [3:0] nbits;
	byte_t dmask;
	logic [15:0] dat_sh;
	logic [4:0] dat_cnt;
	logic [15:0] idle_sh;
	logic [4:0] idle_cnt;

	logic rts_on_reg, rts_on_next;
	logic req_act_reg, req_act_next;
	logic [2:0] req_cnt_reg, req_cnt_next;
	logic tx_cond;

	// Tx clock and rxd come from the line side
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			// Idle level of the line clock, so no false edge follows reset
			tck_sync_reg <= 2'h3;
			rxd_sync_reg <= 2'h3;
			tck_d_reg <= 1'b1;
		end else begin
			tck_sync_reg <= {tck_sync_reg[0], tx_clk};
			rxd_sync_reg <= {rxd_sync_reg[0], rxd};
			tck_d_reg <= tck_sync_reg[1];
		end
	end
	assign tx_fall = tck_d_reg && !tck_sync_reg[1];
	assign tx_rise = !tck_d_reg && tck_sync_reg[1];

	assign cmd_wr = bus.wr && (bus.addr == `A_CMD);
	assign chan_rst = cmd_wr && (bus.wdata[`CM_CRST] || bus.wdata[`CM_HRST]);
	assign eom_clr_cmd = cmd_wr && bus.wdata[`CM_REOM];
	assign txen = txctl_reg[`TC_EN];
	assign async_m = mode_reg[`MD_STOP] != 2'b00;
	assign sdlc = !async_m && (mode_reg[`MD_SYNC] == 2'b10);
	assign x21 = !async_m && (mode_reg[`MD_SYNC] == 2'b00) && misc_reg[`MC_LOOP];
	assign poly = txctl_reg[`TC_POLY] ? `POLY_C16 : `POLY_SDLC;
	assign preset = {16{link_reg[`LK_PRE]}};
	assign status = {eom_reg, rts_on_reg, fifo_empty, fifo_full, st_reg != ST_IDLE, brk_reg, 2'b00};

	// Register file
	always_comb begin
		txctl_next = txctl_reg;
		synca_next = synca_reg;
		syncf_next = syncf_reg;
		enh_next = enh_reg;
		link_next = link_reg;
		misc_next = misc_reg;
		ext_next = ext_reg;
		mode_next = mode_reg;
		rdata_next = 8'h00;
		if (bus.wr) begin
			case (bus.addr)
				`A_TXCTL: txctl_next = bus.wdata;
				`A_SYNCA: synca_next = bus.wdata;
				`A_SYNCF: begin
					if (ext_reg[`EXT_WR7P])
						enh_next = {1'b0, bus.wdata[6:0]};
					else
						syncf_next = bus.wdata;
				end
				`A_LINK: link_next = bus.wdata;
				`A_MISC: misc_next = bus.wdata;
				`A_EXT: ext_next = bus.wdata;
				`A_MODE: mode_next = bus.wdata;
				default: ;
			endcase
		end
		// Enhancement register is left alone by both resets
		if (chan_rst) begin
			txctl_next[`TC_EN] = 1'b0;
			txctl_next[`TC_BRK] = 1'b0;
			txctl_next[`TC_RTS] = 1'b0;
		end
		if (cmd_wr && bus.wdata[`CM_HRST])
			mode_next = `MODE_RST;
		if (x21 && rx_char_sync)
			txctl_next[`TC_BRK] = 1'b0;
		if (bus.rd) begin
			case (bus.addr)
				`A_STAT: rdata_next = status;
				`A_X0: rdata_next = enh_reg[`EN_XRD] ? txctl_reg : status;
				`A_X1: rdata_next = enh_reg[`EN_XRD] ? mode_reg : status;
				`A_X2: rdata_next = enh_reg[`EN_XRD] ? enh_reg : status;
				`A_X3: rdata_next = enh_reg[`EN_XRD] ? link_reg : status;
				`A_X4: rdata_next = enh_reg[`EN_XRD] ? misc_reg : status;
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			txctl_reg <= `TXCTL_RST;
			synca_reg <= `ZERO_RST;
			syncf_reg <= `ZERO_RST;
			enh_reg <= `ZERO_RST;
			link_reg <= `ZERO_RST;
			misc_reg <= `ZERO_RST;
			ext_reg <= `ZERO_RST;
			mode_reg <= `MODE_RST;
			rdata_reg <= `ZERO_RST;
		end else begin
			txctl_reg <= txctl_next;
			synca_reg <= synca_next;
			syncf_reg <= syncf_next;
			enh_reg <= enh_next;
			link_reg <= link_next;
			misc_reg <= misc_next;
			ext_reg <= ext_next;
			mode_reg <= mode_next;
			rdata_reg <= rdata_next;
		end
	end
	assign rdata = rdata_reg;
	assign sync_address = synca_reg;
	assign sync_flag = syncf_reg;
	assign crc16_sel = txctl_reg[`TC_POLY];
	assign crc_preset_ones = link_reg[`LK_PRE];

	// Transmit FIFO accepts data even while disabled
	assign fifo_empty = fcnt_reg == '0;
	assign fifo_full = fcnt_reg == (PW+1)'(TX_DEPTH);
	assign push = bus.wr && (bus.addr == `A_DATA) && !fifo_full;

	always_comb begin
		wp_next = wp_reg;
		rp_next = rp_reg;
		fcnt_next = fcnt_reg;
		if (push)
			wp_next = (wp_reg == PW'(TX_DEPTH - 1)) ? '0 : wp_reg + 1'b1;
		if (pop)
			rp_next = (rp_reg == PW'(TX_DEPTH - 1)) ? '0 : rp_reg + 1'b1;
		if (push && !pop)
			fcnt_next = fcnt_reg + 1'b1;
		else if (pop && !push)
			fcnt_next = fcnt_reg - 1'b1;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wp_reg <= '0;
			rp_reg <= '0;
			fcnt_reg <= '0;
		end else begin
			wp_reg <= wp_next;
			rp_reg <= rp_next;
			fcnt_reg <= fcnt_next;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push)
			fifo_mem[wp_reg] <= bus.wdata;
	end

	// Character framing from the head of the FIFO
	always_comb begin
		unique case (txctl_reg[`TC_LEN])
			2'b00: begin
				if (!fifo_mem[rp_reg][7])
					nbits = 4'd5;
				else if (!fifo_mem[rp_reg][6])
					nbits = 4'd4;
				else if (!fifo_mem[rp_reg][5])
					nbits = 4'd3;
				else if (!fifo_mem[rp_reg][4])
					nbits = 4'd2;
				else
					nbits = 4'd1;
			end
			2'b01: nbits = 4'd7;
			2'b10: nbits = 4'd6;
			2'b11: nbits = 4'd8;
		endcase
		dmask = ~(8'hFF << nbits);
		if (async_m) begin
			dat_sh = (16'hFFFF << (nbits + 4'd1)) | {7'h00, fifo_mem[rp_reg] & dmask, 1'b0};
			dat_cnt = 5'(nbits) + 5'd1 + ((mode_reg[`MD_STOP] == 2'b01) ? 5'd1 : 5'd2);
		end else begin
			dat_sh = {8'hFF, fifo_mem[rp_reg] & dmask};
			dat_cnt = 5'(nbits);
		end
		// Marking idle is one bit long so a new character starts promptly
		if (!txen || async_m || (sdlc && link_reg[`LK_MARK])) begin
			idle_sh = 16'hFFFF;
			idle_cnt = 5'd1;
		end else if (sdlc) begin
			idle_sh = {8'hFF, syncf_reg};
			idle_cnt = 5'd8;
		end else if (mode_reg[`MD_SYNC] == 2'b01) begin
			idle_sh = {syncf_reg, synca_reg};
			idle_cnt = 5'd16;
		end else begin
			idle_sh = {8'hFF, synca_reg};
			idle_cnt = 5'd8;
		end
	end

	assign avail = !fifo_empty && txen;
	assign take = avail && (st_reg == ST_OPEN || st_reg == ST_DATA ||
		(st_reg == ST_IDLE && !(sdlc && enh_reg[`EN_AFLG])));

	// Shifter, CRC and end-of-message latch
	always_comb begin
		st_next = st_reg;
		sh_next = sh_reg;
		cnt_next = cnt_reg;
		crc_next = crc_reg;
		crc_on_next = crc_on_reg;
		eom_next = eom_reg;
		txbit_next = txbit_reg;
		brk_next = brk_reg;
		last_next = last_reg;
		ld_sh = sh_reg;
		ld_cnt = cnt_reg;
		pop = 1'b0;
		if (eom_clr_cmd) begin
			eom_next = 1'b0;
			crc_next = preset;
		end
		if (chan_rst) begin
			st_next = ST_IDLE;
			cnt_next = 5'd0;
			crc_next = preset;
			eom_next = 1'b0;
			brk_next = 1'b0;
			last_next = 1'b0;
		end else if (tx_fall) begin
			brk_next = txctl_reg[`TC_BRK];
			// CRC is abandoned once disabled; a partial character never is
			if (cnt_reg == 5'd0 || (st_reg == ST_CRC && !txen)) begin
				if (take) begin
					ld_sh = dat_sh;
					ld_cnt = dat_cnt;
					pop = 1'b1;
					st_next = ST_DATA;
					crc_on_next = txctl_reg[`TC_CRC];
					if (enh_reg[`EN_AEOM] && eom_reg) begin
						eom_next = 1'b0;
						crc_next = preset;
					end
				end else begin
					unique case (st_reg)
						ST_IDLE: begin
							if (avail) begin
								ld_sh = {8'hFF, syncf_reg};
								ld_cnt = 5'd8;
								st_next = ST_OPEN;
							end else begin
								ld_sh = idle_sh;
								ld_cnt = idle_cnt;
							end
						end
						ST_OPEN, ST_DATA: begin
							if (async_m) begin
								ld_sh = idle_sh;
								ld_cnt = idle_cnt;
								st_next = ST_IDLE;
							end else if (!eom_reg && txctl_reg[`TC_CRC]) begin
								eom_next = 1'b1;
								ld_sh = sdlc ? ~crc_next : crc_next;
								ld_cnt = 5'd16;
								st_next = ST_CRC;
							end else begin
								eom_next = 1'b1;
								ld_sh = sdlc ? {8'hFF, syncf_reg} : idle_sh;
								ld_cnt = sdlc ? 5'd8 : idle_cnt;
								st_next = sdlc ? ST_CLOSE : ST_IDLE;
							end
						end
						ST_CRC: begin
							ld_sh = sdlc ? {8'hFF, syncf_reg} : idle_sh;
							ld_cnt = sdlc ? 5'd8 : idle_cnt;
							st_next = sdlc ? ST_CLOSE : ST_IDLE;
						end
						ST_CLOSE: begin
							ld_sh = idle_sh;
							ld_cnt = idle_cnt;
							st_next = ST_IDLE;
						end
					endcase
				end
			end
			txbit_next = ld_sh[0];
			if (st_next == ST_DATA && crc_on_next && !async_m)
				crc_next = crc_step(crc_next, ld_sh[0], poly);
			sh_next = {1'b1, ld_sh[15:1]};
			cnt_next = ld_cnt - 5'd1;
			last_next = (st_next == ST_CLOSE) && (ld_cnt == 5'd1);
		end
		// Break and the loop paths override the shifter
		if (brk_reg)
			txd_next = 1'b0;
		else if (misc_reg[`MC_ECHO] || (misc_reg[`MC_LOOP] && !txen))
			txd_next = rxd_sync_reg[1];
		else
			txd_next = txbit_reg;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= ST_IDLE;
			sh_reg <= 16'hFFFF;
			cnt_reg <= 5'd0;
			crc_reg <= 16'h0000;
			crc_on_reg <= 1'b0;
			eom_reg <= 1'b0;
			txbit_reg <= 1'b1;
			brk_reg <= 1'b0;
			last_reg <= 1'b0;
			txd_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			sh_reg <= sh_next;
			cnt_reg <= cnt_next;
			crc_reg <= crc_next;
			crc_on_reg <= crc_on_next;
			eom_reg <= eom_next;
			txbit_reg <= txbit_next;
			brk_reg <= brk_next;
			last_reg <= last_next;
			txd_reg <= txd_next;
		end
	end
	assign txd = txd_reg;

	// Send request and request pins
	assign tx_cond = enh_reg[`EN_TXLVL] ? fifo_empty : !fifo_full;

	always_comb begin
		rts_on_next = 1'b0;
		// Next value, so the pin moves with the register write
		if (txctl_next[`TC_RTS])
			rts_on_next = 1'b1;
		else if (async_m && mode_reg[`MD_AUTOEN])
			rts_on_next = rts_on_reg && (!fifo_empty || st_reg != ST_IDLE);
		else if (sdlc && !link_reg[`LK_FOU] && enh_reg[`EN_ARTS])
			rts_on_next = rts_on_reg && !(tx_rise && last_reg) &&
				!(st_reg == ST_IDLE && fifo_empty && !last_reg);
		req_act_next = req_act_reg;
		req_cnt_next = 3'd0;
		if (tx_cond && !(bus.wr && bus.addr == `A_DATA)) begin
			req_act_next = 1'b1;
		end else if (req_act_reg) begin
			// Slow release keeps the base device's timing
			if (enh_reg[`EN_REQT] || req_cnt_reg == `REQ_DLY - 3'd1)
				req_act_next = 1'b0;
			else
				req_cnt_next = req_cnt_reg + 3'd1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rts_on_reg <= 1'b0;
			req_act_reg <= 1'b0;
			req_cnt_reg <= 3'd0;
		end else begin
			rts_on_reg <= rts_on_next;
			req_act_reg <= req_act_next;
			req_cnt_reg <= req_cnt_next;
		end
	end
	assign rts_b = !rts_on_reg;
	assign req_b = !(req_act_reg && misc_reg[`MC_REQM]);
	assign tx_buf_irq = tx_cond;
	assign tx_dma_req = tx_cond && misc_reg[`MC_DMA];
	assign rx_avail_irq = rx_all_int_en &&
		(enh_reg[`EN_RXLVL] ? rx_fifo_count >= `RX_HALF : rx_fifo_count != 4'h0);
	assign rx_special_irq = rx_all_int_en && rx_special_load;
endmodule : serial_tx_cfg

// *** core/tx_cfg_params.svh ***
// Offsets, field positions and reset values of the transmit configuration block
`ifndef TX_CFG_PARAMS_SVH
`define TX_CFG_PARAMS_SVH
`define A_TXCTL 4'h0
`define A_SYNCA 4'h1
`define A_SYNCF 4'h2
`define A_LINK 4'h3
`define A_MISC 4'h4
`define A_EXT 4'h5
`define A_MODE 4'h6
`define A_CMD 4'h7
`define A_DATA 4'h8
`define A_STAT 4'h9
`define A_X0 4'hA
`define A_X1 4'hB
`define A_X2 4'hC
`define A_X3 4'hD
`define A_X4 4'hE
`define TC_CRC 0
`define TC_RTS 1
`define TC_POLY 2
`define TC_EN 3
`define TC_BRK 4
`define TC_LEN 6:5
`define EN_XRD 6
`define EN_TXLVL 5
`define EN_REQT 4
`define EN_RXLVL 3
`define EN_ARTS 2
`define EN_AEOM 1
`define EN_AFLG 0
`define LK_FOU 2
`define LK_MARK 3
`define LK_PRE 7
`define MC_DMA 0
`define MC_REQM 2
`define MC_ECHO 3
`define MC_LOOP 4
`define EXT_WR7P 0
`define MD_AUTOEN 0
`define MD_STOP 3:2
`define MD_SYNC 5:4
`define CM_CRST 0
`define CM_HRST 1
`define CM_REOM 2
`define TXCTL_RST 8'h00
`define MODE_RST 8'h04
`define ZERO_RST 8'h00
`define POLY_C16 16'hA001
`define POLY_SDLC 16'h8408
`define REQ_DLY 3'd4
`define RX_HALF 4'h4
`endif

// *** core/tx_cfg_pkg.sv ***
// Types shared by the transmit configuration block
package tx_cfg_pkg;
	typedef logic [7:0] byte_t;
	typedef struct packed {
		logic [3:0] addr;
		byte_t wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef enum {ST_IDLE, ST_OPEN, ST_DATA, ST_CRC, ST_CLOSE} tx_state_e;
endpackage : tx_cfg_pkg
